// ===== hdl/asc_ctrl.sv
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module asc_ctrl
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // power management
  input  wire logic        standby,
  input  wire logic        module_stop,
  // trigger sources
  input  wire logic        ext_trigger_pin,
  input  wire logic        timer_module_trig,
  // axi4-lite slave
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // converter side
  output logic             conv_active,
  output logic [2:0]       conv_channel,
  output logic             chan_done,
  output logic             conv_done_irq
);

  // ==========================================================================
  // state
  asc_ctrl_t   ctrl_q;
  logic        run_q;
  logic        done_q;
  logic        done_seen_q;
  logic [1:0]  trg_q;
  asc_state_t  st_q;
  logic [8:0]  cnt_q;
  logic [2:0]  ch_q;
  logic [EV_W-1:0] ev_q;
  logic [EV_W-1:0] ev_en_q;
  logic        pin_s1_q, pin_s2_q, pin_s3_q;
  logic        tmr_s1_q, tmr_s2_q, tmr_s3_q;
  logic        aw_q, w_q;
  asc_wr_t     wr_q;

  // ==========================================================================
  // trigger synchronisers and edge detect
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {pin_s1_q, pin_s2_q, pin_s3_q} <= 3'h7;
      {tmr_s1_q, tmr_s2_q, tmr_s3_q} <= 3'h0;
    end else begin
      {pin_s1_q, pin_s2_q, pin_s3_q} <= {ext_trigger_pin, pin_s1_q, pin_s2_q};
      {tmr_s1_q, tmr_s2_q, tmr_s3_q} <= {timer_module_trig, tmr_s1_q, tmr_s2_q};
    end
  end

  // trigger qualification; codes 00/01 leave both starts off
  wire pin_fall  = pin_s3_q & ~pin_s2_q;
  wire tmr_rise  = tmr_s2_q & ~tmr_s3_q;
  wire hw_start  = (trg_q == TRG_PIN & pin_fall)
                 | (trg_q == TRG_TIMER & tmr_rise);

  // ==========================================================================
  // axi write path: address and data taken in either order
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire wr_go    = aw_q & w_q & ~s_axi_bvalid;
  wire wr_csr   = wr_go & (wr_q.addr == CSR_OFFSET) & wr_q.strb[0];
  wire wr_trg   = wr_go & (wr_q.addr == TRG_OFFSET) & wr_q.strb[0];
  wire wr_en    = wr_go & (wr_q.addr == IRQ_EN_OFFSET) & wr_q.strb[0];
  wire wr_clr   = wr_go & (wr_q.addr == IRQ_CLR_OFFSET) & wr_q.strb[0];
  wire wr_hit   = (wr_q.addr == CSR_OFFSET) | (wr_q.addr == TRG_OFFSET)
                | (wr_q.addr == IRQ_CLR_OFFSET) | (wr_q.addr == IRQ_EN_OFFSET);
  wire [7:0] wb = wr_q.data[7:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q  <= 1'b0;
      wr_q <= '0;
    end else begin
      if (aw_take) begin
        aw_q         <= 1'b1;
        wr_q.addr    <= s_axi_awaddr;
      end
      if (w_take) begin
        w_q          <= 1'b1;
        wr_q.data    <= s_axi_wdata;
        wr_q.strb    <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
      end
    end
  end

  // response one cycle after both halves are held
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_q & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_q & ~w_take & ~s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // axi read path
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire [7:0] csr_rd = {done_q, ctrl_q.irq_en, run_q, ctrl_q.scan, ctrl_q.speed, ctrl_q.chan};
  wire [7:0] trg_rd = {trg_q, TRG_RSVD_VAL};
  wire rd_csr   = s_axi_araddr == CSR_OFFSET;
  wire rd_trg   = s_axi_araddr == TRG_OFFSET;
  wire rd_stat  = s_axi_araddr == IRQ_STAT_OFFSET;
  wire rd_en    = s_axi_araddr == IRQ_EN_OFFSET;
  wire rd_clr   = s_axi_araddr == IRQ_CLR_OFFSET;
  wire [31:0] rd_mux = rd_csr  ? {24'h000000, csr_rd}
                     : rd_trg  ? {24'h000000, trg_rd}
                     : rd_stat ? {{(32-EV_W){1'b0}}, ev_q}
                     : rd_en   ? {{(32-EV_W){1'b0}}, ev_en_q}
                     : 32'h00000000;
  wire rd_hit   = rd_csr | rd_trg | rd_stat | rd_en | rd_clr;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // done flag seen as one by a read arms the clear
  wire done_read = ar_take & rd_csr & done_q;

  // ==========================================================================
  // conversion sequencer
  // fields as they stand after this edge; run may be set together with a new mode
  asc_ctrl_t   ctrl_nx;
  assign ctrl_nx = wr_csr ? asc_ctrl_t'({wb[IRQ_EN_BIT], wb[SCAN_BIT], wb[SPEED_BIT],
                                         wb[CH_LSB+:3]})
                          : ctrl_q;
  wire [8:0] first_len = ctrl_nx.speed ? CONV_FAST_CYC : CONV_SLOW_CYC;
  wire [8:0] next_len  = ctrl_q.speed ? SCAN_FAST_CYC : SCAN_SLOW_CYC;
  wire [2:0] grp_first = {ctrl_q.chan[2], 2'b00};
  wire [2:0] grp_last  = ctrl_q.chan;
  wire [2:0] start_ch  = ctrl_nx.scan ? {ctrl_nx.chan[2], 2'b00}
                                      : ctrl_nx.chan;
  wire       conv_end  = (st_q == ASC_CONV) & (cnt_q == 9'h001);
  wire       last_ch   = ~ctrl_q.scan | (ch_q == grp_last);
  wire       halt      = standby | module_stop;
  wire       sw_run_1  = wr_csr & wb[RUN_BIT];
  wire       sw_run_0  = wr_csr & ~wb[RUN_BIT];
  wire       go        = (sw_run_1 | hw_start) & ~halt
                       & ~(ctrl_nx.chan[2] & ctrl_nx.chan[1]);
  wire       set_done  = conv_end & last_ch;

  // run bit: software or trigger start, halt by software/standby/stop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_q <= 1'b0;
    end else if (halt | sw_run_0) begin
      run_q <= 1'b0;
    end else if (go) begin
      run_q <= 1'b1;
    end else if (conv_end & ~ctrl_q.scan) begin
      run_q <= 1'b0;
    end
  end

  // channel counter; a fresh start always reloads the first channel
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q    <= ASC_IDLE;
      cnt_q   <= 9'h000;
      ch_q    <= 3'h0;
    end else if (halt | sw_run_0 | (conv_end & ~ctrl_q.scan)) begin
      st_q <= ASC_IDLE;
    end else begin
      case (st_q)
        ASC_IDLE: begin
          if (go) begin
            st_q    <= ASC_CONV;
            cnt_q   <= first_len;
            ch_q    <= start_ch;
          end
        end
        ASC_CONV: begin
          if (conv_end) begin
            cnt_q   <= next_len;
            ch_q    <= last_ch ? grp_first : 3'(ch_q + 3'h1);
          end else begin
            cnt_q <= 9'(cnt_q - 9'h001);
          end
        end
        default: st_q <= ASC_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // control fields; changes while running are software's duty
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q  <= asc_ctrl_t'({CSR_RESET[IRQ_EN_BIT], CSR_RESET[SCAN_BIT],
                              CSR_RESET[SPEED_BIT], CSR_RESET[CH_LSB+:3]});
      trg_q   <= TRG_RESET;
      ev_en_q <= '0;
    end else begin
      if (wr_csr) begin
        ctrl_q <= ctrl_nx;
      end
      if (wr_trg) begin
        trg_q <= wb[TRG_LSB+:2];
      end
      if (wr_en) begin
        ev_en_q <= wb[EV_W-1:0];
      end
    end
  end

  // done flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_q      <= 1'b0;
      done_seen_q <= 1'b0;
    end else if (set_done) begin
      done_q      <= 1'b1;
    end else if (wr_csr & ~wb[DONE_FLAG_BIT] & done_seen_q) begin
      done_q      <= 1'b0;
      done_seen_q <= 1'b0;
    end else if (done_read) begin
      done_seen_q <= 1'b1;
    end
  end

  // sticky event status, write-one clear, set wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ev_q <= '0;
    end else begin
      ev_q <= (ev_q & ~(wr_clr ? wb[EV_W-1:0] : '0))
            | {conv_end, set_done};
    end
  end

  // ==========================================================================
  // outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_active   <= 1'b0;
      conv_channel  <= 3'h0;
      chan_done     <= 1'b0;
      conv_done_irq <= 1'b0;
    end else begin
      conv_active   <= st_q == ASC_CONV;
      conv_channel  <= ch_q;
      chan_done     <= conv_end;
      conv_done_irq <= (done_q & ctrl_q.irq_en)
                     | |(ev_q & ev_en_q);
    end
  end

  // ==========================================================================
  // assertions
  a_irq_follows_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (done_q & ctrl_q.irq_en) |=> conv_done_irq)
    else $error("irq not raised for enabled done flag");

  a_single_autoclear: assert property (@(posedge ref_clk) disable iff (rst)
    (conv_end & ~ctrl_q.scan & ~halt & ~sw_run_0 & ~go) |=> ~run_q)
    else $error("single mode run bit not cleared");

  a_scan_keeps_run: assert property (@(posedge ref_clk) disable iff (rst)
    (run_q & ctrl_q.scan & ~halt & ~sw_run_0) |=> run_q)
    else $error("scan run bit dropped unexpectedly");

  a_halt_stops: assert property (@(posedge ref_clk) disable iff (rst)
    halt |=> (~run_q & st_q == ASC_IDLE))
    else $error("standby did not stop conversion");

  a_slow_length: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(st_q == ASC_CONV) & ~ctrl_q.speed) |-> cnt_q == 9'd266)
    else $error("slow conversion length wrong");

  a_fast_length: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(st_q == ASC_CONV) & ctrl_q.speed) |-> cnt_q == 9'd134)
    else $error("fast conversion length wrong");

  a_reserved_ones: assert property (@(posedge ref_clk) disable iff (rst)
    (ar_take & rd_trg) |=> s_axi_rdata[5:0] == 6'h3F)
    else $error("reserved trigger bits not one");

  a_flag_no_one_clr: assert property (@(posedge ref_clk) disable iff (rst)
    (done_q & ~done_seen_q) |=> done_q)
    else $error("done flag cleared without prior read");

  a_pin_starts: assert property (@(posedge ref_clk) disable iff (rst)
    (trg_q == TRG_PIN & pin_fall & ~halt & ~sw_run_0 & ~run_q & ~ctrl_nx.chan[2]) |=> run_q)
    else $error("pin falling edge did not start");

  a_scan_first_ch: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(st_q == ASC_CONV) & ctrl_q.scan) |-> ch_q == {ctrl_q.chan[2], 2'b00})
    else $error("scan did not start at group head");

endmodule

// ===== hdl/asc_pkg.sv
package asc_pkg;

  // ==========================================================================
  // register map (byte addresses on the AXI4-Lite slave)
  localparam logic [4:0] CSR_OFFSET      = 5'h00;  // conversion_control_status
  localparam logic [4:0] TRG_OFFSET      = 5'h04;  // trigger_control
  localparam logic [4:0] IRQ_STAT_OFFSET = 5'h08;  // sticky event status, read only
  localparam logic [4:0] IRQ_CLR_OFFSET  = 5'h0C;  // write one to clear, write only
  localparam logic [4:0] IRQ_EN_OFFSET   = 5'h10;  // event enable, same layout as status

  // ==========================================================================
  // conversion_control_status fields
  localparam int DONE_FLAG_BIT = 7;
  localparam int IRQ_EN_BIT    = 6;
  localparam int RUN_BIT       = 5;
  localparam int SCAN_BIT      = 4;
  localparam int SPEED_BIT     = 3;
  localparam int CH_LSB        = 0;
  localparam logic [7:0] CSR_RESET = 8'h00;

  // trigger_control fields
  localparam int TRG_LSB = 6;
  localparam logic [5:0] TRG_RSVD_VAL = 6'h3F;
  localparam logic [1:0] TRG_RESET    = 2'h0;
  localparam logic [1:0] TRG_TIMER    = 2'h2;
  localparam logic [1:0] TRG_PIN      = 2'h3;

  // interrupt status / clear layout
  localparam int EV_DONE_BIT = 0;
  localparam int EV_CHAN_BIT = 1;
  localparam int EV_W        = 2;

  // ==========================================================================
  // timing in states (one state = one ref_clk cycle, 10 ns)
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_SLOW_NS  = 2660;  // longest conversion, speed bit 0
  localparam int CONV_FAST_NS  = 1340;  // longest conversion, speed bit 1
  localparam int SCAN_SLOW_NS  = 2560;  // later scan conversions, speed 0
  localparam int SCAN_FAST_NS  = 1280;  // later scan conversions, speed 1
  localparam logic [8:0] CONV_SLOW_CYC = 9'(CONV_SLOW_NS / CLK_PERIOD_NS);
  localparam logic [8:0] CONV_FAST_CYC = 9'(CONV_FAST_NS / CLK_PERIOD_NS);
  localparam logic [8:0] SCAN_SLOW_CYC = 9'(SCAN_SLOW_NS / CLK_PERIOD_NS);
  localparam logic [8:0] SCAN_FAST_CYC = 9'(SCAN_FAST_NS / CLK_PERIOD_NS);

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // converter state and carrier types
  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_CONV
  } asc_state_t;

  typedef struct packed {
    logic       irq_en;
    logic       scan;
    logic       speed;
    logic [2:0] chan;
  } asc_ctrl_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } asc_wr_t;

endpackage

// ===== verification/tb.sv
`timescale 1ns/100ps
module tb;
  import asc_pkg::*;
  // ==========================================================================
  // design connections and bench state
  logic        ref_clk, rst, standby, module_stop, ext_trigger_pin, timer_module_trig;
  logic [4:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [31:0] wdata, rdata, rd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rs;
  logic        conv_active, chan_done, conv_done_irq;
  logic [2:0]  conv_channel, ch, code;
  int          n_errors, check_count, cycles, c, n, last;
  int          exp_q[$];

  asc_ctrl asc_ctrl_i (
    .ref_clk(ref_clk), .rst(rst), .standby(standby), .module_stop(module_stop),
    .ext_trigger_pin(ext_trigger_pin), .timer_module_trig(timer_module_trig),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_active(conv_active),
    .conv_channel(conv_channel), .chan_done(chan_done), .conv_done_irq(conv_done_irq)
  );

  // ==========================================================================
  // clock and hang guard; the run needs about 3000 cycles
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // counts edges to the next channel end; samples the channel mid-conversion
  task automatic wait_done();
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
      if (c == 20) ch = conv_channel;
    end while (chan_done !== 1'b1 && c < 400);
  endtask

  task tally_and_finish;
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {rst, standby, module_stop, timer_module_trig} = 4'hF;
    {standby, module_stop, timer_module_trig} = 3'h0;
    ext_trigger_pin = 1'b1;
    {awaddr, araddr, wstrb, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {n_errors, check_count, cycles} = '0;
    void'($urandom(43));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd_reg(CSR_OFFSET);
    check("csr reset", rd, 32'h00);
    check("read resp", rs, RESP_OKAY);
    wr(TRG_OFFSET, 8'h00);
    check("write resp", rs, RESP_OKAY);
    rd_reg(TRG_OFFSET);
    check("trg fixed", rd, 32'h3F);
    rd_reg(5'h01);
    check("unmapped resp", rs, RESP_SLVERR);
    wr(5'h01, 8'hFF);
    check("unmapped wr resp", rs, RESP_SLVERR);
    // a prohibited channel code must not start a conversion
    wr(CSR_OFFSET, 8'h2E);
    rd_reg(CSR_OFFSET);
    check("bad chan run", {rd[5], conv_active}, 0);
    // single conversion at both speeds, random channel, fields set with run
    for (int sp = 1; sp >= 0; sp--) begin
      n = $urandom_range(5, 0);
      wr(CSR_OFFSET, 8'(8'h60 | (sp << 3) | n));
      wait_done();
      check("single len", c <= (sp ? 134 : 266) && c >= (sp ? 131 : 259), 1);
      check("single chan", ch, n);
      repeat (3) @(posedge ref_clk);
      check("irq on done", conv_done_irq, 1);
      wr(CSR_OFFSET, 8'(8'h40 | (sp << 3) | n));
      rd_reg(CSR_OFFSET);
      check("csr end", rd, 32'hC0 | (sp << 3) | n);
      wr(CSR_OFFSET, rd[7:0]);
      rd_reg(CSR_OFFSET);
      check("flag w1", rd[7], 1);
      wr(CSR_OFFSET, 8'h00);
      rd_reg(CSR_OFFSET);
      check("flag w0", rd, 0);
      check("irq clear", conv_done_irq, 0);
    end
    // scan over a random group, two full passes
    code = 3'($urandom_range(5, 0));
    last = code[2] ? 4 + code[0] : code[1:0];
    for (int i = code[2] ? 4 : 0; i <= last; i++) begin
      exp_q.push_back(i);
    end
    wr(CSR_OFFSET, 8'h38 | code);
    for (int k = 0; k < 2 * exp_q.size(); k++) begin
      wait_done();
      check("scan chan", ch, exp_q[k % exp_q.size()]);
      if (k > 0) check("scan gap", c, 128);
    end
    rd_reg(CSR_OFFSET);
    check("scan run done", rd[7:5], 3'b101);
    wr(CSR_OFFSET, 8'h18 | code);
    repeat (3) @(posedge ref_clk);
    check("halt", conv_active, 0);
    rd_reg(CSR_OFFSET);
    check("halt run", rd[7:5], 3'b000);
    wr(CSR_OFFSET, 8'h38 | code);
    wait_done();
    check("restart chan", ch, exp_q[0]);
    // reset in mid-scan drops the run bit and every field
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd_reg(CSR_OFFSET);
    check("reset run", {rd[7:0], conv_active}, 0);
    // standby and module stop both end a scan
    for (int m = 0; m < 2; m++) begin
      wr(CSR_OFFSET, 8'h38 | code);
      repeat (5) @(posedge ref_clk);
      if (m == 0) standby <= 1'b1;
      else module_stop <= 1'b1;
      repeat (3) @(posedge ref_clk);
      {standby, module_stop} <= 2'b00;
      rd_reg(CSR_OFFSET);
      check("stop run", {rd[5], conv_active}, 0);
    end
    // every trigger code with a pin fall and a timer rise, set while stopped
    for (int t = 0; t < 4; t++) begin
      wr(CSR_OFFSET, 8'h08);
      wr(TRG_OFFSET, 8'(t << 6));
      ext_trigger_pin <= 1'b1;
      repeat (5) @(posedge ref_clk);
      ext_trigger_pin   <= 1'b0;
      timer_module_trig <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd_reg(CSR_OFFSET);
      check("trig start", {rd[5], conv_active}, t >= 2 ? 3 : 0);
      wait_done();
      timer_module_trig <= 1'b0;
    end
    // sticky status: clear, enable, mask
    wr(TRG_OFFSET, 8'h00);
    rd_reg(IRQ_STAT_OFFSET);
    check("status set", rd, 32'h3);
    wr(IRQ_CLR_OFFSET, 8'h03);
    rd_reg(IRQ_STAT_OFFSET);
    check("status clr", rd, 0);
    wr(IRQ_EN_OFFSET, 8'h03);
    rd_reg(IRQ_EN_OFFSET);
    check("enable back", rd, 32'h3);
    check("irq idle", conv_done_irq, 0);
    wr(CSR_OFFSET, 8'h28);
    wait_done();
    repeat (3) @(posedge ref_clk);
    check("irq enabled", conv_done_irq, 1);
    wr(IRQ_EN_OFFSET, 8'h00);
    repeat (2) @(posedge ref_clk);
    check("irq masked", conv_done_irq, 0);
    tally_and_finish();
  end
endmodule
